// [rx_frame_pkg.sv]
package rx_frame_pkg;
    // =========================================
    // Register map
    localparam logic [7:0] ADDR_RX_EVENT_FLAGS = 8'h06;
    localparam logic [7:0] ADDR_RX_CONTROL_TWO = 8'h16;
    localparam logic [7:0] RX_CONTROL_TWO_RESET = 8'h00;
    localparam logic [7:0] RX_EVENT_FLAGS_RESET = 8'h00;
    // Control two field positions
    localparam int BIT_BUFFER_HELD = 7;
    localparam int BIT_DUP_REJECT = 6;
    localparam int BIT_ACK_IN_PEND = 5;
    localparam int BIT_ACK_OUT_PEND = 4;
    localparam int BIT_AUTO_REPEAT = 3;
    localparam int BIT_AUTO_ACK = 2;
    localparam int BIT_ADAPT_CH = 1;
    localparam int BIT_ADAPT_RATE = 0;
    // Event flag positions
    localparam int FLG_RX_SUCCESS = 7;
    localparam int FLG_SEC_PASS = 6;
    localparam int FLG_SEC_FAIL = 5;
    localparam int FLG_DUPLICATE = 3;
    localparam int FLG_FILTERED = 2;
    localparam int FLG_OVERFLOW = 1;
    localparam int FLG_STREAM_TO = 0;
    // Writable bits of control two
    localparam logic [7:0] CTRL_WR_MASK = 8'h5F;
    // Transfer modes
    localparam logic [1:0] MODE_PACKET = 2'h0;
    localparam logic [1:0] MODE_RX_STREAM = 2'h1;

    typedef struct packed {
        logic [15:0] src_addr;
        logic [7:0] seq_num;
        logic filter_pass;
        logic repeat_bit;
        logic ack_req_bit;
        logic is_std_ack;
        logic frame_pending;
        logic proprietary;
        logic [3:0] info_channel;
        logic [2:0] info_rate;
    } frame_info_t;

    typedef struct packed {
        logic proprietary;
        logic frame_pending;
        logic [3:0] channel;
        logic [2:0] rate;
    } ack_req_t;
endpackage

// [rx_frame_control_status.sv]
module rx_frame_control_status (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_link_clk,
    // Host register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Host-side control
    input wire logic [1:0] i_transfer_mode_select,
    input wire logic i_receive_enable_bit,
    input wire logic i_transmit_start_request,
    input wire logic i_stream_timeout,
    input wire logic i_stream_buffer_consumed,
    input wire logic i_sec_done,
    input wire logic i_sec_error,
    input wire logic [3:0] i_channel_setting,
    input wire logic [2:0] i_data_rate_setting,
    // Link-side frame report (link clock domain) and responses (reference clock)
    input wire logic i_frame_valid,
    input wire rx_frame_pkg::frame_info_t i_frame_info,
    output logic o_frame_accept,
    output logic [1:0] o_write_buffer,
    output logic o_ack_send,
    output rx_frame_pkg::ack_req_t o_ack_req,
    output logic o_repeat_send,
    output logic o_seq_cleared,
    output logic o_abort_frame
);

    // =========================================
    // Link domain: capture frame, toggle event
    rx_frame_pkg::frame_info_t link_info;
    logic link_toggle;

    always_ff @(posedge i_link_clk) begin
        if (!i_reset_n) begin
            link_info <= '0;
        end else if (i_frame_valid) begin
            link_info <= i_frame_info;
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (!i_reset_n) begin
            link_toggle <= 1'b0;
        end else if (i_frame_valid) begin
            link_toggle <= ~link_toggle;
        end
    end

    // =========================================
    // Crossing into reference domain
    logic [2:0] tog_sync;
    logic frame_event;
    rx_frame_pkg::frame_info_t info;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            tog_sync <= 3'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], link_toggle};
        end
    end

    logic load_info;
    assign load_info = tog_sync[2] ^ tog_sync[1];

    // Event registered on the same edge as the info capture
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            frame_event <= 1'b0;
        end else begin
            frame_event <= load_info;
        end
    end

    // Held stable for many link cycles after the toggle
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            info <= '0;
        end else if (load_info) begin
            info <= link_info;
        end
    end

    // =========================================
    // Synchronise host-side pin levels
    logic [1:0] en_sync;
    logic [1:0] to_sync;
    logic [1:0] rx_en_q;
    logic [1:0] to_q;

    // Two stages before any logic reads the pins
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            en_sync <= 2'h0;
            to_sync <= 2'h0;
        end else begin
            en_sync <= {en_sync[0], i_receive_enable_bit};
            to_sync <= {to_sync[0], i_stream_timeout};
        end
    end

    // Delayed copies for edge detection
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            rx_en_q <= 2'h0;
            to_q <= 2'h0;
        end else begin
            rx_en_q <= {rx_en_q[0], en_sync[1]};
            to_q <= {to_q[0], to_sync[1]};
        end
    end

    logic rx_on;
    logic timeout_event;
    logic streaming;
    assign rx_on = rx_en_q[0];
    assign timeout_event = to_q[0] & ~to_q[1];
    assign streaming =
        (i_transfer_mode_select == rx_frame_pkg::MODE_RX_STREAM);

    // =========================================
    // Frame classification
    logic [15:0] last_src;
    logic [7:0] last_seq;
    logic last_valid;
    logic [1:0] buf_full;
    logic wr_sel;
    logic rd_sel;
    logic [7:0] ctrl;
    logic is_dup;
    logic room;
    logic accept;
    logic ev_dup;
    logic ev_flt;
    logic ev_ovf;

    // Duplicate check
    // match last source and sequence number
    assign is_dup = ctrl[rx_frame_pkg::BIT_DUP_REJECT] & last_valid
        & (info.src_addr == last_src) & (info.seq_num == last_seq);
    assign room = streaming ? ~buf_full[wr_sel] : ~buf_full[0];
    assign accept = frame_event & rx_on & ~info.is_std_ack
        & info.filter_pass & ~is_dup & room;
    assign ev_dup = frame_event & rx_on & ~info.is_std_ack
        & info.filter_pass & is_dup;
    assign ev_flt = frame_event & rx_on & ~info.is_std_ack
        & ~info.filter_pass;
    assign ev_ovf = frame_event & rx_on & ~info.is_std_ack
        & info.filter_pass & ~is_dup & ~room;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            last_src <= 16'h0000;
            last_seq <= 8'h00;
            last_valid <= 1'b0;
        end else if (accept) begin
            last_src <= info.src_addr;
            last_seq <= info.seq_num;
            last_valid <= 1'b1;
        end else if (streaming && timeout_event) begin
            last_valid <= 1'b0;
            last_seq <= 8'h00;
        end
    end

    // =========================================
    // Buffer ownership
    logic host_clear_held;
    logic reg_wr_ctrl;
    logic reg_rd_flags;
    assign reg_wr_ctrl = i_reg_wr
        && (i_reg_addr == rx_frame_pkg::ADDR_RX_CONTROL_TWO);
    assign reg_rd_flags = i_reg_rd
        && (i_reg_addr == rx_frame_pkg::ADDR_RX_EVENT_FLAGS);
    assign host_clear_held = reg_wr_ctrl
        & ~i_reg_wdata[rx_frame_pkg::BIT_BUFFER_HELD];

    logic advance_read;
    assign advance_read = i_stream_buffer_consumed | host_clear_held;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            wr_sel <= 1'b0;
        end else if (!streaming) begin
            wr_sel <= 1'b0;
        end else if (accept) begin
            wr_sel <= ~wr_sel;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            rd_sel <= 1'b0;
        end else if (!streaming) begin
            rd_sel <= 1'b0;
        end else if (advance_read) begin
            rd_sel <= ~rd_sel;
        end
    end

    // One held bit per buffer
    for (genvar b = 0; b < 2; b++) begin : g_buf
        logic fill;
        logic drain;
        assign fill = accept & (streaming ? (wr_sel == 1'(b)) : (b == 0));
        assign drain = streaming ? (advance_read & (rd_sel == 1'(b)))
            : (host_clear_held | (b != 0));
        always_ff @(posedge i_ref_clk) begin
            if (!i_reset_n) begin
                buf_full[b] <= 1'b0;
            end else if (fill) begin
                buf_full[b] <= 1'b1;
            end else if (drain) begin
                buf_full[b] <= 1'b0;
            end
        end
    end

    logic held_view;
    assign held_view = streaming ? buf_full[rd_sel] : buf_full[0];

    // =========================================
    // Control register
    logic ack_in_pend;

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ctrl <= rx_frame_pkg::RX_CONTROL_TWO_RESET;
        end else if (reg_wr_ctrl) begin
            ctrl <= i_reg_wdata & rx_frame_pkg::CTRL_WR_MASK;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            ack_in_pend <= 1'b0;
        end else if (frame_event && info.is_std_ack) begin
            ack_in_pend <= info.frame_pending;
        end
    end

    // =========================================
    // Event flags
    logic [7:0] flags;
    logic [7:0] set_vec;

    always_comb begin
        set_vec = 8'h00;
        set_vec[rx_frame_pkg::FLG_RX_SUCCESS] = accept;
        set_vec[rx_frame_pkg::FLG_SEC_PASS] = i_sec_done & ~i_sec_error;
        set_vec[rx_frame_pkg::FLG_SEC_FAIL] = i_sec_done & i_sec_error;
        set_vec[rx_frame_pkg::FLG_DUPLICATE] = ev_dup;
        set_vec[rx_frame_pkg::FLG_FILTERED] = ev_flt;
        set_vec[rx_frame_pkg::FLG_OVERFLOW] = ev_ovf;
        set_vec[rx_frame_pkg::FLG_STREAM_TO] = streaming & timeout_event;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            flags <= rx_frame_pkg::RX_EVENT_FLAGS_RESET;
        end else if (reg_rd_flags) begin
            flags <= set_vec;
        end else begin
            flags <= flags | set_vec;
        end
    end

    // =========================================
    // Read data
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (i_reg_addr == rx_frame_pkg::ADDR_RX_EVENT_FLAGS) begin
                o_reg_rdata <= flags;
            end else if (i_reg_addr == rx_frame_pkg::ADDR_RX_CONTROL_TWO) begin
                o_reg_rdata <= {held_view, ctrl[6], ack_in_pend, ctrl[4:0]};
            end else begin
                // Unmapped addresses read as zero
                o_reg_rdata <= 8'h00;
            end
        end
    end

    // =========================================
    // Link-facing outputs (reference clock)
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_frame_accept <= 1'b0;
            o_write_buffer <= 2'h0;
            o_ack_send <= 1'b0;
            o_ack_req <= '0;
            o_repeat_send <= 1'b0;
            o_seq_cleared <= 1'b0;
            o_abort_frame <= 1'b0;
        end else begin
            o_frame_accept <= accept;
            // Write index tracks the next buffer to be written in stream mode, zero otherwise
            o_write_buffer <= streaming ? {1'b0, wr_sel} : 2'h0;
            o_ack_send <= accept & info.ack_req_bit
                & ctrl[rx_frame_pkg::BIT_AUTO_ACK];
            o_repeat_send <= accept & info.repeat_bit
                & ctrl[rx_frame_pkg::BIT_AUTO_REPEAT];
            o_seq_cleared <= streaming & timeout_event;
            o_abort_frame <= rx_en_q[1] & ~rx_en_q[0];
            if (accept) begin
                o_ack_req.proprietary <= info.proprietary;
                o_ack_req.frame_pending
                    <= ctrl[rx_frame_pkg::BIT_ACK_OUT_PEND];
                o_ack_req.channel <= (info.proprietary
                    && ctrl[rx_frame_pkg::BIT_ADAPT_CH])
                    ? info.info_channel : i_channel_setting;
                o_ack_req.rate <= (info.proprietary
                    && ctrl[rx_frame_pkg::BIT_ADAPT_RATE])
                    ? info.info_rate : i_data_rate_setting;
            end
        end
    end

endmodule

// [link_frame_source.sv]
module link_frame_source (
    input wire logic i_link_clk,
    output logic o_frame_valid,
    output rx_frame_pkg::frame_info_t o_frame_info
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Frame reports
    initial begin
        o_frame_valid = 1'b0;
        o_frame_info = '0;
    end
    // One-cycle report, info scrambled once released
    task automatic send(input rx_frame_pkg::frame_info_t f);
        @(posedge i_link_clk);
        o_frame_valid <= 1'b1;
        o_frame_info <= f;
        @(posedge i_link_clk);
        o_frame_valid <= 1'b0;
        o_frame_info <= ~f;
    endtask
endmodule

// [rx_frame_control_status_properties.sv]
module rx_frame_control_status_properties (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_receive_enable_bit,
    input wire logic [3:0] i_channel_setting,
    input wire logic [2:0] i_data_rate_setting,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_frame_accept,
    input wire logic o_ack_send,
    input wire rx_frame_pkg::ack_req_t o_ack_req,
    input wire logic o_repeat_send,
    input wire logic o_abort_frame
);
    // ==========
    // Control shadow
    logic [7:0] cfg;
    logic cfg_wr;
    assign cfg_wr = i_reg_wr &&
        (i_reg_addr == rx_frame_pkg::ADDR_RX_CONTROL_TWO);
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            cfg <= 8'h00;
        end else if (cfg_wr) begin
            cfg <= i_reg_wdata;
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    sequence s_plain_ack;
        o_ack_send && !o_ack_req.proprietary;
    endsequence
    sequence s_rx_drop;
        $fell(i_receive_enable_bit);
    endsequence
    chk_ack_with_accept: assert property (
        o_ack_send |-> o_frame_accept)
        else $error("Ack without accept");
    chk_ack_auto_off: assert property (o_ack_send |-> $past(cfg[2]))
        else $error("Ack while auto ack off");
    chk_rpt_with_accept: assert property (
        o_repeat_send |-> o_frame_accept)
        else $error("Repeat without accept");
    chk_rpt_auto_off: assert property (o_repeat_send |-> $past(cfg[3]))
        else $error("Repeat while auto repeat off");
    chk_accept_once: assert property (
        o_frame_accept |=> (!o_frame_accept)[*3])
        else $error("Accept pulse repeated");
    chk_ack_chan_cfg: assert property (
        s_plain_ack |-> o_ack_req.channel == $past(i_channel_setting))
        else $error("Ack channel wrong");
    chk_ack_rate_cfg: assert property (
        s_plain_ack |-> o_ack_req.rate == $past(i_data_rate_setting))
        else $error("Ack rate wrong");
    chk_ack_pend_bit: assert property (
        s_plain_ack |-> o_ack_req.frame_pending == $past(cfg[4]))
        else $error("Ack pending bit wrong");
    chk_abort_on_drop: assert property (
        s_rx_drop |-> ##[1:6] o_abort_frame)
        else $error("No abort after receive disable");
    chk_rdata_stands: assert property (
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("Read data moved without read");
endmodule
bind rx_frame_control_status rx_frame_control_status_properties i_props (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_receive_enable_bit(i_receive_enable_bit),
    .i_channel_setting(i_channel_setting),
    .i_data_rate_setting(i_data_rate_setting), .o_reg_rdata(o_reg_rdata),
    .o_frame_accept(o_frame_accept), .o_ack_send(o_ack_send),
    .o_ack_req(o_ack_req), .o_repeat_send(o_repeat_send),
    .o_abort_frame(o_abort_frame)
);

// [rx_frame_control_status_tb.sv]
module rx_frame_control_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Stimulus and wiring
    localparam logic [7:0] CT = rx_frame_pkg::ADDR_RX_CONTROL_TWO;
    localparam logic [7:0] FL = rx_frame_pkg::ADDR_RX_EVENT_FLAGS;
    logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic rx_en = 1'b0, sto = 1'b0, sdone = 1'b0, serr = 1'b0, cons = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic [1:0] mode = 2'h0;
    logic [7:0] rdata;
    logic [1:0] wbuf;
    logic fvalid, acc, ack, rpt, sclr, abt, ack_seen, rpt_seen;
    logic sclr_seen = 1'b0, abt_seen = 1'b0;
    rx_frame_pkg::frame_info_t finfo;
    rx_frame_pkg::ack_req_t areq;
    int num_errors = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    initial begin
        #1.3;
        forever #3 lclk = ~lclk;
    end
    rx_frame_control_status i_rx_frame_control_status (
        .i_ref_clk(clk), .i_reset_n(rst_n), .i_link_clk(lclk),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_transfer_mode_select(mode), .i_receive_enable_bit(rx_en),
        .i_transmit_start_request(1'b0), .i_stream_timeout(sto),
        .i_stream_buffer_consumed(cons), .i_sec_done(sdone),
        .i_sec_error(serr), .i_channel_setting(4'h3),
        .i_data_rate_setting(3'h2), .i_frame_valid(fvalid),
        .i_frame_info(finfo), .o_frame_accept(acc), .o_write_buffer(wbuf),
        .o_ack_send(ack), .o_ack_req(areq), .o_repeat_send(rpt),
        .o_seq_cleared(sclr), .o_abort_frame(abt)
    );
    link_frame_source i_link_frame_source (
        .i_link_clk(lclk), .o_frame_valid(fvalid), .o_frame_info(finfo)
    );
    always @(posedge clk) begin
        if (sclr === 1'b1) sclr_seen <= 1'b1;
        if (abt === 1'b1) abt_seen <= 1'b1;
    end
    // ==========
    // Tasks
    task automatic check(input logic [8:0] s, input logic [8:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", samples_checked,
            num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({1'b0, rdata}, {1'b0, e});
    endtask
    task automatic sec(input logic err);
        @(posedge clk);
        sdone <= 1'b1;
        serr <= err;
        @(posedge clk);
        sdone <= 1'b0;
    endtask
    // Bits: pass, repeat, ack request, std ack, pending, proprietary
    function automatic rx_frame_pkg::frame_info_t mk(input logic [7:0] q,
        input logic [5:0] b);
        mk = {16'hBEEF, q, b, 4'hA, 3'h5};
    endfunction
    task automatic run_frame(input rx_frame_pkg::frame_info_t f,
        input logic e_acc, input logic [7:0] e_flags);
        logic got;
        got = 1'b0;
        i_link_frame_source.send(f);
        repeat (20) begin
            @(posedge clk);
            #1;
            if (acc === 1'b1) begin
                got = 1'b1;
                ack_seen = ack;
                rpt_seen = rpt;
            end
        end
        check({8'h00, got}, {8'h00, e_acc});
        reg_read(FL, e_flags);
    endtask
    // ==========
    // Tests
    initial begin
        #100us;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(CT, rx_frame_pkg::RX_CONTROL_TWO_RESET);
        reg_read(FL, rx_frame_pkg::RX_EVENT_FLAGS_RESET);
        reg_read(8'h2A, 8'h00);
        reg_write(CT, 8'hFF);
        reg_read(CT, 8'h5F);
        @(posedge clk);
        rx_en <= 1'b1;
        repeat (6) @(posedge clk);
        run_frame(mk(8'h01, 6'b111001), 1'b1, 8'h80);
        check({7'h00, ack_seen, rpt_seen}, 9'h003);
        check({2'h0, areq[6:0]}, 9'h055);
        reg_read(FL, 8'h00);
        reg_read(CT, 8'hDF);
        run_frame(mk(8'h02, 6'b100000), 1'b0, 8'h02);
        reg_write(CT, 8'h5F);
        reg_read(CT, 8'h5F);
        run_frame(mk(8'h01, 6'b100000), 1'b0, 8'h08);
        run_frame(mk(8'h03, 6'b000000), 1'b0, 8'h04);
        run_frame(mk(8'h04, 6'b100110), 1'b0, 8'h00);
        reg_read(CT, 8'h7F);
        run_frame(mk(8'h05, 6'b111000), 1'b1, 8'h80);
        check({areq}, 9'h09A);
        reg_write(CT, 8'h5F);
        sec(1'b0);
        reg_read(FL, 8'h40);
        sec(1'b1);
        reg_read(FL, 8'h20);
        // Event on the same edge as a clearing read
        @(posedge clk);
        sdone <= 1'b1;
        serr <= 1'b0;
        rd <= 1'b1;
        addr <= FL;
        @(posedge clk);
        sdone <= 1'b0;
        rd <= 1'b0;
        reg_read(FL, 8'h40);
        reg_write(CT, 8'h13);
        reg_read(CT, 8'h33);
        run_frame(mk(8'h05, 6'b111000), 1'b1, 8'h80);
        check({7'h00, ack_seen, rpt_seen}, 9'h000);
        reg_write(CT, 8'h13);
        @(posedge clk);
        mode <= rx_frame_pkg::MODE_RX_STREAM;
        sto <= 1'b1;
        repeat (8) @(posedge clk);
        reg_read(FL, 8'h01);
        check({8'h00, sclr_seen}, 9'h001);
        run_frame(mk(8'h06, 6'b100000), 1'b1, 8'h80);
        check({7'h00, wbuf}, 9'h001);
        reg_read(CT, 8'hB3);
        run_frame(mk(8'h07, 6'b100000), 1'b1, 8'h80);
        check({7'h00, wbuf}, 9'h000);
        run_frame(mk(8'h08, 6'b100000), 1'b0, 8'h02);
        reg_write(CT, 8'h13);
        reg_read(CT, 8'hB3);
        @(posedge clk);
        cons <= 1'b1;
        @(posedge clk);
        cons <= 1'b0;
        reg_read(CT, 8'h33);
        @(posedge clk);
        rx_en <= 1'b0;
        repeat (8) @(posedge clk);
        check({8'h00, abt_seen}, 9'h001);
        tally_and_finish();
    end
endmodule
